// ---- design/tacs_pin_sync.sv ----
/*
 * Three-flop pin synchroniser with agreement filter and edge pulses.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module tacs_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds s2 only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
        fall <= ~s3;
      end
    end
  end
endmodule : tacs_pin_sync
`default_nettype wire

// ---- design/tacs_pkg.sv ----
/*
 * Package for the touch-converter control byte sequencer: control byte
 * layout, power-down codes, sequence counts and carried structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tacs_pkg;

  localparam int CMD_WIDTH = 8;
  localparam int START_POS = 7;
  localparam int CHAN_MSB = 6;
  localparam int CHAN_LSB = 4;
  localparam int RES_POS = 3;
  localparam int REFCFG_POS = 2;
  localparam int PD_MSB = 1;
  localparam int PD_LSB = 0;

  localparam logic [1:0] PD_AUTO = 2'h0;
  localparam logic [1:0] PD_REF_OFF_ADC_ON = 2'h1;
  localparam logic [1:0] PD_REF_ON_ADC_OFF = 2'h2;
  localparam logic [1:0] PD_ALWAYS_ON = 2'h3;

  // shift-clock edges after the start marker at which acquisition begins
  localparam logic [4:0] ACQ_EDGE = 5'h4;
  // control byte complete: hold and convert
  localparam logic [4:0] HOLD_EDGE = 5'h7;
  localparam logic [4:0] CONV_BITS_12 = 5'h0C;
  localparam logic [4:0] CONV_BITS_8 = 5'h08;
  localparam int RESULT_WIDTH = 12;

  localparam int HOLD_LIMIT_NS = 1600000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HOLD_LIMIT_CYCLES = HOLD_LIMIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0] channelSelectField;
    logic eightBit;
    logic refConfigBit;
    logic [1:0] powerDownField;
  } tacs_cmd_t;

  typedef struct packed {
    logic refOn;
    logic adcOn;
    logic penIrqEnable;
    logic yMinusOn;
  } tacs_power_t;

  typedef enum logic [1:0] {
    IDLE,
    SHIFT,
    CONVERT
  } tacs_state_t;

endpackage : tacs_pkg

// ---- design/tacs_sequencer.sv ----
/*
 * Control byte decoder and conversion sequencer of a touch-screen converter.
 * Assumes a host driving shiftClock, serialIn and csN on a synchronous serial
 * link much slower than clk; the successive-approximation core supplies one
 * result bit (sarBit) per conversion clock while sarPhase is high.
 */
`timescale 1ns/10ps
`default_nettype none
module tacs_sequencer
  import tacs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic shiftClock,
  input wire logic serialIn,
  input wire logic csN,
  input wire logic sarBit,
  output logic serialOut,
  output logic serialOutEn,
  output logic busy,
  output logic busyEn,
  output logic acquire,
  output logic hold,
  output logic sarPhase,
  output tacs_pkg::tacs_cmd_t activeCmd,
  output tacs_pkg::tacs_power_t power,
  output logic singleEndedRef,
  output logic holdTimeout
);
  import tacs_pkg::*;

  logic clkLevel;
  logic clkRise;
  logic clkFall;
  logic dinLevel;
  logic csLevel;

  tacs_state_t state;
  logic [CMD_WIDTH-2:0] shiftReg;
  logic [4:0] bitCount;
  logic [4:0] convCount;
  logic [4:0] convBits;
  logic converting;
  logic [RESULT_WIDTH-1:0] result;
  logic [4:0] outLeft;
  logic refLatched;
  logic [1:0] pdCode;
  logic [$clog2(HOLD_LIMIT_CYCLES+1)-1:0] holdTimer;

  function automatic tacs_cmd_t decodeCmd(input logic [CMD_WIDTH-1:0] b);
    tacs_cmd_t c;
    c.channelSelectField = b[CHAN_MSB:CHAN_LSB];
    c.eightBit = b[RES_POS];
    c.refConfigBit = b[REFCFG_POS];
    c.powerDownField = b[PD_MSB:PD_LSB];
    return c;
  endfunction : decodeCmd

  tacs_pin_sync clkSync (
    .clk(clk),
    .rst(rst),
    .pin(shiftClock),
    .level(clkLevel),
    .rise(clkRise),
    .fall(clkFall)
  );
  tacs_pin_sync dinSync (
    .clk(clk),
    .rst(rst),
    .pin(serialIn),
    .level(dinLevel),
    .rise(),
    .fall()
  );
  // reset idles deselected: level starts 0, so invert sense of the synced copy
  tacs_pin_sync csSync (
    .clk(clk),
    .rst(rst),
    .pin(~csN),
    .level(csLevel),
    .rise(),
    .fall()
  );

  // command capture; sampling on rising shift clock edges
  always_ff @(posedge clk) begin
    if (rst || !csLevel) begin
      state <= IDLE;
      shiftReg <= '0;
      bitCount <= '0;
      activeCmd <= '0;
      busy <= 1'b0;
      acquire <= 1'b0;
      hold <= 1'b0;
    end else if (clkRise) begin
      busy <= 1'b0;
      case (state)
        IDLE: begin
          if (dinLevel) begin
            state <= SHIFT;
            bitCount <= 5'h1;
          end
        end
        SHIFT: begin
          shiftReg <= {shiftReg[CMD_WIDTH-3:0], dinLevel};
          bitCount <= bitCount + 5'h1;
          if (bitCount == ACQ_EDGE) begin
            acquire <= 1'b1;
            hold <= 1'b0;
          end
          if (bitCount == HOLD_EDGE) begin
            activeCmd <= decodeCmd({1'b1, shiftReg[CMD_WIDTH-3:0], dinLevel});
            acquire <= 1'b0;
            hold <= 1'b1;
            state <= IDLE;
            bitCount <= '0;
          end
        end
        default: state <= IDLE;
      endcase
    end else if (clkFall && converting && convCount == 5'h0) begin
      // one pulse on the fall that closes the byte; cleared by the next rise
      busy <= 1'b1;
    end
  end

  // conversion clocks; next byte may arrive while these run
  always_ff @(posedge clk) begin
    if (rst || !csLevel) begin
      converting <= 1'b0;
      convCount <= '0;
      convBits <= CONV_BITS_12;
      result <= '0;
      sarPhase <= 1'b0;
    end else begin
      if (clkRise && state == SHIFT && bitCount == HOLD_EDGE) begin
        converting <= 1'b1;
        convCount <= '0;
        convBits <= convLength(shiftReg);
        result <= '0;
        sarPhase <= 1'b1;
      end else if (clkRise && converting) begin
        result <= {result[RESULT_WIDTH-2:0], sarBit};
        convCount <= convCount + 5'h1;
        if (convCount + 5'h1 == convBits) begin
          converting <= 1'b0;
          sarPhase <= 1'b0;
        end
      end
    end
  end

  function automatic logic serialInRes(input logic [CMD_WIDTH-2:0] s);
    // resolution bit sits two places above the newest shifted bit
    return s[RES_POS-1];
  endfunction : serialInRes

  // conversion length chosen by the resolution bit of the byte in flight
  function automatic logic [4:0] convLength(input logic [CMD_WIDTH-2:0] s);
    return serialInRes(s) ? CONV_BITS_8 : CONV_BITS_12;
  endfunction : convLength

  // straight binary, msb first; each bit leaves on the fall after the rise
  // that resolved it, so the last bit is out by the twelfth clock
  always_ff @(posedge clk) begin
    if (rst || !csLevel) begin
      outLeft <= '0;
      serialOut <= 1'b0;
    end else if (clkRise && state == SHIFT && bitCount == HOLD_EDGE) begin
      outLeft <= convLength(shiftReg);
    end else if (clkFall) begin
      if (outLeft != 5'h0 && convCount != 5'h0) begin
        serialOut <= result[0];
        outLeft <= outLeft - 5'h1;
      end else begin
        serialOut <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serialOutEn <= 1'b0;
      busyEn <= 1'b0;
    end else begin
      serialOutEn <= csLevel;
      busyEn <= csLevel;
    end
  end

  // reference latched as hold rises, held through deselect
  always_ff @(posedge clk) begin
    if (rst) begin
      refLatched <= 1'b0;
    end else if (clkRise && state == SHIFT && bitCount == HOLD_EDGE) begin
      refLatched <= shiftReg[PD_MSB-1];
    end
  end

  always_comb begin
    pdCode = activeCmd.powerDownField;
  end

  // power control: reference and converter handled apart
  always_ff @(posedge clk) begin
    if (rst) begin
      power <= '{refOn: 1'b0, adcOn: 1'b0, penIrqEnable: 1'b1, yMinusOn: 1'b1};
      singleEndedRef <= 1'b1;
    end else begin
      power.refOn <= refLatched;
      // converter on during any active conversion, gaps included
      // hold stays up after the byte, so it must not keep the converter on
      power.adcOn <= csLevel && (converting || acquire || pdCode[0]);
      power.penIrqEnable <= (pdCode != PD_ALWAYS_ON);
      power.yMinusOn <= (pdCode == PD_AUTO) && !converting && !acquire;
      singleEndedRef <= activeCmd.refConfigBit;
    end
  end

  // flags a conversion that is held too long for the sample to stay valid
  always_ff @(posedge clk) begin
    if (rst || !converting) begin
      holdTimer <= '0;
      holdTimeout <= 1'b0;
    end else if (holdTimer != HOLD_LIMIT_CYCLES[$bits(holdTimer)-1:0]) begin
      holdTimer <= holdTimer + 1'b1;
    end else begin
      holdTimeout <= 1'b1;
    end
  end
endmodule : tacs_sequencer
`default_nettype wire

// ---- verification/tacs_host_model.sv ----
/* Host serial port model: shift clock, data and select; logs serial output.
   Assumes clk at 50 MHz; one shift clock is eight clk periods. */
`timescale 1ns/10ps
`default_nettype none
module tacs_host_model (
  input wire logic clk,
  input wire logic serialOut,
  output logic shiftClock,
  output logic serialIn,
  output logic csN
);
  logic [63:0] rxLog = '0;
  int riseNo = 0;
  int curStart = -100;
  int prevStart = -100;
  initial begin
    shiftClock = 1'b0;
    serialIn = 1'b0;
    csN = 1'b1;
  end
  task automatic halfStep();
    repeat (4) @(posedge clk);
    #1;
  endtask : halfStep
  task automatic sel(input logic v);
    @(posedge clk);
    #1 csN = v;
    repeat (6) @(posedge clk);
  endtask : sel
  // clock idles low between frames; short frames keep each hold well inside limits
  task automatic frame(input logic [7:0] cmd, input int lead, input int n);
    @(posedge clk);
    #1;
    for (int k = 0; k < lead + n; k++) begin
      serialIn = (k >= lead && k < lead + 8) ? cmd[7 - (k - lead)] : 1'b0;
      halfStep();
      shiftClock = 1'b1;
      riseNo++;
      if (k == lead && cmd[7]) begin
        prevStart = curStart;
        curStart = riseNo;
      end
      halfStep();
      rxLog = {rxLog[62:0], serialOut};
      shiftClock = 1'b0;
    end
  endtask : frame
endmodule : tacs_host_model
`default_nettype wire

// ---- verification/tacs_sequencer_props.sv ----
/* Port assertions for the control byte sequencer.
   Assumes binding to tacs_sequencer with clk at 50 MHz. */
`timescale 1ns/10ps
`default_nettype none
module tacs_sequencer_props
  import tacs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic serialOutEn,
  input wire logic acquire,
  input wire logic hold,
  input wire logic sarPhase,
  input wire tacs_pkg::tacs_cmd_t activeCmd,
  input wire tacs_pkg::tacs_power_t power,
  input wire logic singleEndedRef
);
  import tacs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] phaseLen;
  // saturates so a stuck phase cannot wrap back into range
  always_ff @(posedge clk) begin
    if (rst || !sarPhase) phaseLen <= 8'h00;
    else if (phaseLen != 8'hFF) phaseLen <= phaseLen + 8'h01;
  end
  sequence acqStart;
    $rose(acquire);
  endsequence
  sequence holdSoon;
    ##[16:40] (hold || csN);
  endsequence
  a_acq_to_hold: assert property (acqStart |-> holdSoon)
    else $error("hold late after acquisition");
  a_conv_length: assert property ($fell(sarPhase) && !csN |->
    (activeCmd.eightBit ? (phaseLen inside {[56:80]}) : (phaseLen inside {[88:112]})))
    else $error("conversion length wrong");
  a_pen_irq_gate: assert property ($stable(activeCmd) [*3] |->
    power.penIrqEnable == (activeCmd.powerDownField != PD_ALWAYS_ON))
    else $error("pen interrupt gate wrong");
  a_ref_follows_pd: assert property (sarPhase [*3] |->
    power.refOn == activeCmd.powerDownField[1])
    else $error("reference power wrong");
  a_conv_powered: assert property (sarPhase [*3] |-> power.adcOn)
    else $error("converter off in conversion");
  a_ref_mode_sel: assert property (sarPhase [*3] |->
    singleEndedRef == activeCmd.refConfigBit)
    else $error("reference mode wrong");
  a_auto_power_down: assert property ($fell(sarPhase) && !csN &&
    activeCmd.powerDownField == PD_AUTO |-> ##[1:8] (!power.adcOn && power.yMinusOn))
    else $error("auto power down missing");
  a_abort_clears: assert property (csN [*8] |->
    !sarPhase && !acquire && !hold && !serialOutEn)
    else $error("deselect did not abort");
  a_abort_keeps_ref: assert property (csN [*8] |=> $stable(power.refOn))
    else $error("deselect changed reference");
endmodule : tacs_sequencer_props
`default_nettype wire

// ---- verification/tacs_sequencer_tb.sv ----
/* Self-checking bench for the control byte sequencer.
   Assumes the package, host model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tacs_sequencer_tb;
  import tacs_pkg::*;
  localparam logic [11:0] PAT = 12'hA5C;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sarBit = 1'b0;
  logic shiftClock, serialIn, csN, serialOut, serialOutEn, busy, busyEn;
  logic acquire, hold, sarPhase, singleEndedRef, holdTimeout;
  tacs_cmd_t activeCmd;
  tacs_power_t power;
  logic [7:0] cmd;
  int busyCnt = 0;
  int mismatches = 0;
  int nTests = 0;
  int d;
  always #10 clk = ~clk;
  tacs_host_model host (.clk(clk), .serialOut(serialOut), .shiftClock(shiftClock),
    .serialIn(serialIn), .csN(csN));
  tacs_sequencer uut (.clk(clk), .rst(rst), .shiftClock(shiftClock), .serialIn(serialIn),
    .csN(csN), .sarBit(sarBit), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .busy(busy), .busyEn(busyEn), .acquire(acquire), .hold(hold), .sarPhase(sarPhase),
    .activeCmd(activeCmd), .power(power), .singleEndedRef(singleEndedRef),
    .holdTimeout(holdTimeout));
  always @(posedge busy) busyCnt++;
  // stands in for the core; the design sees a rise only after its fall, so index
  // by the rise just made; an overlapped byte must not disturb the older one
  always @(negedge shiftClock) begin
    d = host.riseNo - host.curStart;
    if (d < 8) d = host.riseNo - host.prevStart;
    sarBit <= (d >= 8 && d < 20) ? PAT[19 - d] : 1'b0;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // result starts at the first high bit in the log, since its msb is one
  task automatic chkRes(input int w, input int gap);
    int p;
    logic [63:0] lg;
    logic [11:0] v;
    lg = host.rxLog;
    v = PAT >> (12 - w);
    p = 63;
    while (p > w && lg[p] !== 1'b1) p--;
    chk(32'((lg >> (p - w + 1)) & ((64'h1 << w) - 64'h1)), 32'(v));
    if (gap > 0) chk(32'((lg >> (p - gap - w + 1)) & ((64'h1 << w) - 64'h1)), 32'(v));
    else chk(32'(lg & ((64'h1 << (p - w + 1)) - 64'h1)), 32'h0);
  endtask : chkRes
  task automatic run(input logic [7:0] c, input int lead, input int n);
    host.rxLog = '0;
    busyCnt = 0;
    host.frame(c, lead, n);
    repeat (8) @(posedge clk);
    #1;
    chk(32'(activeCmd), 32'(c[6:0]));
    chk(32'(busyCnt), 32'h1);
  endtask : run
  task automatic results();
    $display("tests %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    #300000;
    mismatches++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    host.sel(1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd = {1'b1, 3'(2 * i + 1), 1'b0, i[0], 2'(i)};
      run(cmd, i, 24);
      chk(32'(power[3:1]), 32'({cmd[1], cmd[0], cmd[1:0] != PD_ALWAYS_ON}));
      chk(32'({singleEndedRef, holdTimeout, busyEn}), 32'({cmd[2], 1'b0, 1'b1}));
      if (i == 0) chk(32'(power.yMinusOn), 32'h1);
      chkRes(12, 0);
      $display("power code %0d done", i);
    end
    run(8'hDA, 0, 24);
    chkRes(8, 0);
    $display("eight bit done");
    host.rxLog = '0;
    host.frame(8'h93, 0, 15);
    host.frame(8'h93, 0, 15);
    host.frame(8'h00, 0, 15);
    chkRes(12, 15);
    $display("overlap done");
    host.frame(8'hD5, 0, 5);
    host.sel(1'b1);
    repeat (8) @(posedge clk);
    #1;
    chk(32'(power.refOn), 32'h1);
    chk(32'({sarPhase, acquire, serialOutEn, busyEn}), 32'h0);
    $display("abort done");
    results();
  end
endmodule : tacs_sequencer_tb
bind tacs_sequencer tacs_sequencer_props props (.clk(clk), .rst(rst), .csN(csN),
  .serialOutEn(serialOutEn), .acquire(acquire), .hold(hold), .sarPhase(sarPhase),
  .activeCmd(activeCmd), .power(power), .singleEndedRef(singleEndedRef));
`default_nettype wire
